// File: dsm_pkg.sv
`default_nettype none
package dsm_pkg;
    localparam logic [7:0] ADDR_SETUP = 8'h00;
    localparam logic [7:0] ADDR_FILT  = 8'h04;
    localparam logic [7:0] ADDR_PLVL  = 8'h08;
    localparam logic [7:0] ADDR_PMEAS = 8'h0C;
    localparam logic [7:0] ADDR_STAT  = 8'h10;
    localparam logic [7:0] SETUP_RST  = 8'h00;
    localparam logic [7:0] FILT_RST   = 8'h00;
    localparam int         SHORT_BIT  = 2;
    localparam int         WIDE_BIT   = 5;
    localparam logic [1:0] RATE_1M    = 2'h0;
    localparam logic [1:0] RATE_2M    = 2'h1;
    localparam logic [1:0] RATE_5M5   = 2'h2;
    localparam logic [1:0] RATE_11M   = 2'h3;
    localparam logic [1:0] SEG_PRE    = 2'h0;
    localparam logic [1:0] SEG_HDR    = 2'h1;
    localparam logic [10:0] BARKER    = 11'h712;
    localparam logic [3:0] BARKER_END = 4'hA;
    localparam logic [3:0] CCK_END    = 4'h7;
    localparam int         NTAP       = 5;
    localparam int         OW         = 12;
    localparam logic [NTAP*8-1:0] TAP_STD  = 40'h10_30_40_30_10;
    localparam logic [NTAP*8-1:0] TAP_WIDE = 40'h08_20_60_20_08;

    typedef enum logic [1:0] {ST_IDLE, ST_LOAD, ST_SEND} dsm_state_e;

    typedef struct packed {
        logic vld;
        logic neg_i;
        logic neg_q;
    } dsm_chip_s;

    typedef struct packed {
        logic                 vld;
        logic signed [OW-1:0] i;
        logic signed [OW-1:0] q;
    } dsm_iq_s;

    // differential dibit code: 00->0, 01->1, 11->2, 10->3 quarter turns
    function automatic logic [1:0] dq_map(input logic b0, input logic b1);
        return {b0, b0 ^ b1};
    endfunction : dq_map

    // quarter-turn phase to sign pair, constellation offset by 45 degrees
    function automatic logic [1:0] ph_neg(input logic [1:0] p);
        return {p[1] ^ p[0], p[1]};
    endfunction : ph_neg
endpackage : dsm_pkg
`default_nettype wire

// File: dsm_tx_modulator.sv
// Summary of operation
// R1: DBPSK, DQPSK, CCK at 1/2/5.5/11 Mbps
// R2: preamble DBPSK, then switch rate automatically
// R3: separate I and Q outputs always
// R4: DBPSK drives I=Q, Barker spread
// R5: DQPSK dibits 00/01/11/10 give 0/+90/180/-90
// R6: DQPSK bits split to I and Q, Barker
// R7: CCK symbol is eight complex chips
// R8: phi2 odd, phi3 pairs, phi4 quads, two negations
// R9: CCK chips sent least significant first
// R10: CCK phi1 differential versus previous symbol
// R11: last CCK chip carries phi1 only
// R12: 5.5 Mbps nibbles, first dibit sets phi1
// R13: odd payload symbols get extra half turn
// R14: phi1 change table, odd symbols plus pi
// R15: 5.5 Mbps phi2, phi3, phi4 from last dibit
// R16: 11 Mbps eight bits, first pair phi1
// R17: CCK reference is previous CCK symbol
// R18: 11 Mbps binary QPSK for phi2..phi4
// R19: output passes tap-set FIR filter
// R20: control bit selects wider filter shape
// R21: power measurement readable in register
// R22: software writes desired power level
// R23: long header DBPSK, short header DQPSK
// R24: rate field 00/01/10/11 selects modulation
// R25: chip per cycle with valid, phase reset
// R26: pull 1/2/4/8 bits per symbol
`timescale 1ns/100ps
`default_nettype none
module dsm_tx_modulator
    import dsm_pkg::*;
#(
    parameter int PW = 8
) (
    input  wire logic          pclk,
    input  wire logic          presetn,
    input  wire logic          psel,
    input  wire logic          penable,
    input  wire logic          pwrite,
    input  wire logic [7:0]    paddr,
    input  wire logic [31:0]   pwdata,
    output logic      [31:0]   prdata,
    output logic               pready,
    output logic               pslverr,
    input  wire logic          tx_en,
    input  wire logic [1:0]    seg_sel,
    input  wire logic          bit_data,
    input  wire logic          bit_valid,
    output logic               bit_ready,
    output dsm_iq_s            tx_out,
    input  wire logic [PW-1:0] pwr_adc,
    input  wire logic          pwr_adc_valid,
    output logic      [PW-1:0] tx_level
);
    // ---------------- register bus ----------------
    logic [7:0]    setup_q, setup_d;
    logic [7:0]    filt_q, filt_d;
    logic [PW-1:0] plvl_q, plvl_d;
    logic [PW-1:0] pmeas_q, pmeas_d;
    logic [31:0]   prdata_q, prdata_d;
    logic          perr_q, perr_d;
    logic [31:0]   rd_val;
    logic          hit;
    logic          wr;
    logic [7:0]    stat;

    assign wr = psel & penable & pwrite;

    always_comb begin
        hit    = 1'b1;
        rd_val = 32'h0;
        case (paddr)
            ADDR_SETUP: rd_val = {24'h0, setup_q};
            ADDR_FILT:  rd_val = {24'h0, filt_q};
            ADDR_PLVL:  rd_val = 32'(plvl_q);
            ADDR_PMEAS: rd_val = 32'(pmeas_q);      // see R21
            ADDR_STAT:  rd_val = {24'h0, stat};
            default:    hit    = 1'b0;
        endcase
    end

    always_comb begin
        setup_d  = setup_q;
        filt_d   = filt_q;
        plvl_d   = plvl_q;
        pmeas_d  = pwr_adc_valid ? pwr_adc : pmeas_q; // see R21
        prdata_d = prdata_q;
        perr_d   = perr_q;
        if (psel && !penable) begin
            // answer prepared in setup phase, so access needs no wait state
            prdata_d = pwrite ? 32'h0 : rd_val;
            perr_d   = ~hit;
        end
        if (wr && paddr == ADDR_SETUP)
            setup_d = pwdata[7:0];                  // see R24
        if (wr && paddr == ADDR_FILT)
            filt_d = pwdata[7:0];                   // see R20
        if (wr && paddr == ADDR_PLVL)
            plvl_d = pwdata[PW-1:0];                // see R22
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            setup_q  <= SETUP_RST;
            filt_q   <= FILT_RST;
            plvl_q   <= '0;
            pmeas_q  <= '0;
            prdata_q <= 32'h0;
            perr_q   <= 1'b0;
        end else begin
            setup_q  <= setup_d;
            filt_q   <= filt_d;
            plvl_q   <= plvl_d;
            pmeas_q  <= pmeas_d;
            prdata_q <= prdata_d;
            perr_q   <= perr_d;
        end
    end

    assign prdata   = prdata_q;
    assign pready   = 1'b1;
    assign pslverr  = perr_q;
    assign tx_level = plvl_q;

    // ---------------- symbol coder ----------------
    dsm_state_e st_q, st_d;
    logic [2:0] bcnt_q, bcnt_d;
    logic [7:0] sbuf_q, sbuf_d, sb_n;
    logic [3:0] cnt_q, cnt_d;
    logic [1:0] mode_q, mode_d, mode_cur;
    logic [1:0] bph_q, bph_d, cph_q, cph_d;
    logic [1:0] phi1_q, phi1_d, phi2_q, phi2_d;
    logic [1:0] phi3_q, phi3_d, phi4_q, phi4_d;
    logic       odd_q, odd_d, en_q;
    logic [2:0] need;
    logic       take, done, start;
    logic [1:0] cp, neg;
    dsm_chip_s  chip_q, chip_d;

    assign stat = {st_q != ST_IDLE, odd_q, mode_q, cph_q, bph_q};
    assign start = tx_en & ~en_q;
    assign bit_ready = (st_q == ST_LOAD) & tx_en;
    assign take = bit_ready & bit_valid;

    always_comb begin
        if (seg_sel == SEG_PRE)
            mode_cur = RATE_1M;                     // see R2
        else if (seg_sel == SEG_HDR)
            mode_cur = setup_q[SHORT_BIT] ? RATE_2M : RATE_1M; // see R23
        else
            mode_cur = setup_q[1:0];                // see R24
        case (mode_cur)                             // see R26
            RATE_1M:  need = 3'h0;
            RATE_2M:  need = 3'h1;
            RATE_5M5: need = 3'h3;
            default:  need = 3'h7;
        endcase
        sb_n = sbuf_q;
        sb_n[bcnt_q] = bit_data;
        done = take && bcnt_q == need;
    end

    // chip phase: phi2 on chips with index bit0 clear, phi3 bit1, phi4 bit2
    always_comb begin
        cp = phi1_q;                                // see R11
        if (mode_q[1]) begin
            if (!cnt_q[0])
                cp = 2'(cp + phi2_q);               // see R8
            if (!cnt_q[1])
                cp = 2'(cp + phi3_q);               // see R8
            if (!cnt_q[2])
                cp = 2'(cp + phi4_q);               // see R8
            if (cnt_q == 4'h3 || cnt_q == 4'h6)
                cp = 2'(cp + 2'h2);                 // see R8
        end
        neg = ph_neg(cp);                           // see R3
        if (!mode_q[1] && BARKER[cnt_q])
            neg = ~neg;                             // see R4 see R6
    end

    always_comb begin
        st_d   = st_q;
        bcnt_d = bcnt_q;
        sbuf_d = sbuf_q;
        cnt_d  = cnt_q;
        mode_d = mode_q;
        bph_d  = bph_q;
        cph_d  = cph_q;
        odd_d  = odd_q;
        phi1_d = phi1_q;
        phi2_d = phi2_q;
        phi3_d = phi3_q;
        phi4_d = phi4_q;
        chip_d = '0;
        case (st_q)
            ST_IDLE: begin
                if (start) begin
                    st_d   = ST_LOAD;
                    bcnt_d = 3'h0;
                    bph_d  = 2'h0;                  // see R25
                    cph_d  = 2'h0;                  // see R25
                    odd_d  = 1'b0;                  // see R13
                end
            end
            ST_LOAD: begin
                if (take) begin
                    sbuf_d = sb_n;
                    bcnt_d = 3'(bcnt_q + 3'h1);
                end
                if (done) begin
                    st_d   = ST_SEND;
                    bcnt_d = 3'h0;
                    cnt_d  = 4'h0;
                    mode_d = mode_cur;              // see R1 see R2
                    phi2_d = 2'h0;
                    phi3_d = 2'h0;
                    phi4_d = 2'h0;
                    if (mode_cur[1]) begin
                        // separate reference keeps Barker symbols out of it
                        phi1_d = 2'(cph_q + dq_map(sb_n[0], sb_n[1])
                                 + {odd_q, 1'b0});  // see R10 see R14 see R17
                        cph_d  = phi1_d;
                        odd_d  = ~odd_q;            // see R13
                        if (mode_cur == RATE_5M5) begin
                            phi2_d = {sb_n[2], 1'b1}; // see R12 see R15
                            phi4_d = {sb_n[3], 1'b0}; // see R15
                        end else begin
                            phi2_d = {sb_n[2], sb_n[3]}; // see R16 see R18
                            phi3_d = {sb_n[4], sb_n[5]}; // see R18
                            phi4_d = {sb_n[6], sb_n[7]}; // see R18
                        end
                    end else if (mode_cur == RATE_1M) begin
                        phi1_d = 2'(bph_q + {sb_n[0], 1'b0}); // see R4
                        bph_d  = phi1_d;
                    end else begin
                        phi1_d = 2'(bph_q + dq_map(sb_n[0], sb_n[1])); // see R5
                        bph_d  = phi1_d;
                    end
                end
            end
            ST_SEND: begin
                chip_d = '{vld: 1'b1, neg_i: neg[1], neg_q: neg[0]}; // see R25
                cnt_d  = 4'(cnt_q + 4'h1);          // see R9
                if (cnt_q == (mode_q[1] ? CCK_END : BARKER_END))
                    st_d = ST_LOAD;                 // see R7
            end
            default: st_d = ST_IDLE;
        endcase
        if (!tx_en)
            st_d = ST_IDLE;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_q   <= ST_IDLE;
            bcnt_q <= 3'h0;
            sbuf_q <= 8'h00;
            cnt_q  <= 4'h0;
            mode_q <= RATE_1M;
            bph_q  <= 2'h0;
            cph_q  <= 2'h0;
            odd_q  <= 1'b0;
            phi1_q <= 2'h0;
            phi2_q <= 2'h0;
            phi3_q <= 2'h0;
            phi4_q <= 2'h0;
            en_q   <= 1'b0;
            chip_q <= '0;
        end else begin
            st_q   <= st_d;
            bcnt_q <= bcnt_d;
            sbuf_q <= sbuf_d;
            cnt_q  <= cnt_d;
            mode_q <= mode_d;
            bph_q  <= bph_d;
            cph_q  <= cph_d;
            odd_q  <= odd_d;
            phi1_q <= phi1_d;
            phi2_q <= phi2_d;
            phi3_q <= phi3_d;
            phi4_q <= phi4_d;
            en_q   <= tx_en;
            chip_q <= chip_d;
        end
    end

    // ---------------- shaping filter ----------------
    // taps are all positive here, so the output cannot wrap for OW=12
    dsm_chip_s [NTAP-1:0]        sh_q, sh_d;
    logic      [NTAP*8-1:0]      taps;
    logic signed [OW-1:0]        ci [NTAP];
    logic signed [OW-1:0]        cq [NTAP];
    dsm_iq_s                     out_q, out_d;

    assign taps = filt_q[WIDE_BIT] ? TAP_WIDE : TAP_STD; // see R20
    assign sh_d = {sh_q[NTAP-2:0], chip_q};

    genvar k;
    generate
        for (k = 0; k < NTAP; k++) begin : g_tap
            logic signed [OW-1:0] tk;
            assign tk    = OW'(taps[k*8 +: 8]);
            assign ci[k] = !sh_q[k].vld ? '0 : sh_q[k].neg_i ? -tk : tk; // see R19
            assign cq[k] = !sh_q[k].vld ? '0 : sh_q[k].neg_q ? -tk : tk; // see R19
        end
    endgenerate

    always_comb begin
        out_d = '0;
        for (int n = 0; n < NTAP; n++) begin
            out_d.i   = OW'(out_d.i + ci[n]);
            out_d.q   = OW'(out_d.q + cq[n]);
            out_d.vld = out_d.vld | sh_q[n].vld;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sh_q  <= '0;
            out_q <= '0;
        end else begin
            sh_q  <= sh_d;
            out_q <= out_d;
        end
    end

    assign tx_out = out_q;

    // ---------------- checks ----------------
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    logic [3:0] run_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn)
            run_q <= 4'h0;
        else
            run_q <= chip_q.vld ? 4'(run_q + 4'h1) : 4'h0;
    end

    sequence s_latch_cck;
        st_q == ST_LOAD && done && mode_cur[1];
    endsequence

    sequence s_last_cck;
        st_q == ST_SEND && mode_q[1] && cnt_q == CCK_END && tx_en;
    endsequence

    a_dbpsk_same_iq: assert property (               // see R4
        chip_q.vld && mode_q == RATE_1M |-> chip_q.neg_i == chip_q.neg_q)
        else $error("dbpsk chip has different I and Q");
    a_cck_ref_chip: assert property (                // see R11
        s_last_cck |=> chip_q.vld && {chip_q.neg_i, chip_q.neg_q} == ph_neg(phi1_q))
        else $error("last cck chip not at reference phase");
    a_cck_sym_len: assert property (                 // see R7
        s_latch_cck ##1 tx_en [*7] |-> ##3 run_q == 4'h8)
        else $error("cck symbol length is not eight chips");
    a_barker_len: assert property (                  // see R4
        $fell(chip_q.vld) && !$past(mode_q[1], 2) && $past(tx_en, 2)
        |-> run_q == 4'hB)
        else $error("barker symbol length is not eleven chips");
    a_odd_toggle: assert property (                  // see R13
        s_latch_cck |=> odd_q != $past(odd_q))
        else $error("odd symbol flag did not toggle");
    a_dqpsk_step: assert property (                  // see R5
        st_q == ST_LOAD && done && mode_cur == RATE_2M
        |=> bph_q == 2'($past(bph_q) + dq_map($past(sb_n[0]), $past(sb_n[1]))))
        else $error("dqpsk phase step wrong");
    a_pre_dbpsk: assert property (                   // see R2
        st_q == ST_LOAD && done && seg_sel == SEG_PRE |=> mode_q == RATE_1M)
        else $error("preamble symbol not dbpsk");
    a_cck_keep_ref: assert property (                // see R17
        st_q == ST_LOAD && done && !mode_cur[1] |=> cph_q == $past(cph_q))
        else $error("barker symbol moved cck reference");
    a_start_phase: assert property (                 // see R25
        st_q == ST_IDLE && start |=> bph_q == 2'h0 && cph_q == 2'h0 && !odd_q)
        else $error("phase state not cleared at packet start");
    a_meas_read: assert property (                   // see R21
        psel && !penable && !pwrite && paddr == ADDR_PMEAS
        |=> prdata == 32'($past(pmeas_q)))
        else $error("measurement register read wrong");
    a_fir_quiet: assert property (                   // see R19
        !chip_q.vld [*6] |=> tx_out.i == '0 && tx_out.q == '0 && !tx_out.vld)
        else $error("filter output not quiet after idle");
endmodule : dsm_tx_modulator
`default_nettype wire

// File: dsm_upconv_model.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_upconv_model
    import dsm_pkg::*;
(
    input  wire logic    pclk,
    input  wire logic    presetn,
    input  wire dsm_iq_s tx_out,
    input  wire logic    wide,
    output logic         chip_stb,
    output logic [1:0]   chip_neg,
    output logic [15:0]  n_bad
);
    int hi[NTAP];
    int hq[NTAP];
    int si;
    int sq;

    // strip the older taps; what is left must be the newest chip alone,
    // so a wrong coefficient set leaves a residue that gets counted
    function automatic int peel(input int y, input int h[NTAP], input logic w);
        logic [NTAP*8-1:0] t;
        t = w ? TAP_WIDE : TAP_STD;
        for (int k = 1; k < NTAP; k++) begin
            y -= int'(t[k*8 +: 8]) * h[k-1];
        end
        if (y == 0 || y == int'(t[7:0]) || y == -int'(t[7:0])) begin
            return y / int'(t[7:0]);
        end
        return 2;
    endfunction : peel

    always @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            chip_stb <= 1'b0;
            chip_neg <= 2'h0;
            n_bad    <= 16'h0;
            hi = '{default: 0};
            hq = '{default: 0};
        end else begin
            chip_stb <= 1'b0;
            if (tx_out.vld !== 1'b1) begin
                hi = '{default: 0};
                hq = '{default: 0};
            end else begin
                si = peel(int'(tx_out.i), hi, wide);
                sq = peel(int'(tx_out.q), hq, wide);
                if (si == 2 || sq == 2 || (si == 0) != (sq == 0)) begin
                    n_bad <= n_bad + 16'h1;
                end
                for (int k = NTAP - 1; k > 0; k--) begin
                    hi[k] = hi[k-1];
                    hq[k] = hq[k-1];
                end
                hi[0] = si;
                hq[0] = sq;
                // a zero sample is an idle slot between symbols, not a chip
                chip_stb <= (si == 1 || si == -1);
                chip_neg <= {si < 0, sq < 0};
            end
        end
    end
endmodule : dsm_upconv_model
`default_nettype wire

// File: dsm_tx_modulator_test.sv
`timescale 1ns/100ps
`default_nettype none
module dsm_tx_modulator_test import dsm_pkg::*;;
    typedef struct packed {
        logic [1:0]  rate;
        logic        shortp;
        logic        wide;
        logic [19:0] bits;
        logic [15:0] nch;
    } dsm_row_s;

    localparam int LIMIT = 20000;
    // 2 preamble bits, 2 header bits, 16 payload bits; last column is chips seen
    localparam dsm_row_s ROWS[5] = '{
        '{2'h0, 1'b0, 1'b0, 20'h5B3A6, 16'h00DC},
        '{2'h1, 1'b1, 1'b0, 20'hC96E1, 16'h0079},
        '{2'h2, 1'b0, 1'b1, 20'h3F1D4, 16'h004C},
        '{2'h3, 1'b1, 1'b0, 20'hA7E29, 16'h0031},
        '{2'h2, 1'b1, 1'b0, 20'h6D0B7, 16'h0041}
    };

    logic        pclk, presetn, psel, penable, pwrite, pready, pslverr;
    logic [7:0]  paddr, pwr_adc, tx_level;
    logic [31:0] pwdata, prdata, rd;
    logic        tx_en, bit_data, bit_valid, bit_ready, pwr_adc_valid;
    logic [1:0]  seg_sel, chip_neg;
    dsm_iq_s     tx_out;
    logic        wide_sel, chip_stb, er;
    logic [15:0] n_bad;
    logic [19:0] pat;
    logic [1:0]  exp_q[$];
    logic [1:0]  got_q[$];
    int          bref, cref, odd, bi, cyc, n_errors, tests_run;
    int          nbits[4] = '{1, 2, 4, 8};
    int          dq_tab[4] = '{0, 1, 3, 2};

    dsm_tx_modulator uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .tx_en, .seg_sel, .bit_data, .bit_valid, .bit_ready,
        .tx_out, .pwr_adc, .pwr_adc_valid, .tx_level);
    dsm_upconv_model up (.pclk, .presetn, .tx_out, .wide(wide_sel), .chip_stb,
        .chip_neg, .n_bad);

    initial begin
        pclk = 1'b0;
        forever #10 pclk = ~pclk;
    end

    always @(posedge pclk) begin
        if (chip_stb === 1'b1) begin
            got_q.push_back(chip_neg);
        end
        cyc <= cyc + 1;
        if (cyc == LIMIT) begin
            n_errors++;
            wrap_up();
        end
    end

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask : wrap_up

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask : apb

    task automatic rchk(input string nm, input logic [7:0] a, input logic [31:0] e, logic ee);
        apb(1'b0, a, 32'h0);
        chk(nm, e, rd);
        chk(nm, {31'h0, ee}, {31'h0, er});
    endtask : rchk

    // quarter turn to sign pair, the whole chip inverted on request
    task automatic add_chip(input int p, input logic inv);
        exp_q.push_back({p[1] ^ p[0] ^ inv, p[1] ^ inv});
    endtask : add_chip

    task automatic barker(input int dlt);
        bref = (bref + dlt) % 4;
        for (int j = 0; j < 11; j++) begin
            add_chip(bref, BARKER[j]);
        end
    endtask : barker

    task automatic cck(input logic [7:0] d, input int p2, input int p3, input int p4);
        int p;
        cref = (cref + dq_tab[{d[0], d[1]}] + 2 * odd) % 4;
        odd ^= 1;
        for (int j = 0; j < 8; j++) begin
            p = cref + (j % 2 == 0 ? p2 : 0) + (j % 4 < 2 ? p3 : 0) + (j < 4 ? p4 : 0);
            add_chip(p + ((j == 3 || j == 6) ? 2 : 0), 1'b0);
        end
    endtask : cck

    task automatic sym(input logic [1:0] seg, input int m);
        logic [7:0] d;
        d = 8'h00;
        for (int k = 0; k < nbits[m]; k++) begin
            d[k] = pat[bi];
            bi++;
            bit_data <= d[k];
            bit_valid <= 1'b1;
            seg_sel <= seg;
            do @(posedge pclk); while (bit_ready !== 1'b1);
        end
        case (m)
            0: barker(d[0] ? 2 : 0);
            1: barker(dq_tab[{d[0], d[1]}]);
            2: cck(d, 2 * d[2] + 1, 0, 2 * d[3]);
            default: cck(d, 2 * d[2] + d[3], 2 * d[4] + d[5], 2 * d[6] + d[7]);
        endcase
    endtask : sym

    task automatic run_pkt(input dsm_row_s r);
        apb(1'b1, ADDR_SETUP, {29'h0, r.shortp, r.rate});
        apb(1'b1, ADDR_FILT, {26'h0, r.wide, 5'h0});
        wide_sel <= r.wide;
        bref = 0;
        cref = 0;
        odd = 0;
        bi = 0;
        pat = r.bits;
        exp_q.delete();
        got_q.delete();
        tx_en <= 1'b1;
        sym(SEG_PRE, 0);
        sym(SEG_PRE, 0);
        if (r.shortp) begin
            sym(SEG_HDR, 1);
        end else begin
            sym(SEG_HDR, 0);
            sym(SEG_HDR, 0);
        end
        while (bi < 20) begin
            sym({1'b1, r.rate[0]}, int'(r.rate));
        end
        bit_valid <= 1'b0;
        repeat (30) @(posedge pclk);
        tx_en <= 1'b0;
        repeat (8) @(posedge pclk);
        chk("chip count", {16'h0, r.nch}, got_q.size());
        chk("shape residue", 32'h0, {16'h0, n_bad});
        foreach (exp_q[k]) begin
            chk("chip", {30'h0, exp_q[k]}, {30'h0, got_q[k]});
        end
    endtask : run_pkt

    initial begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        tx_en = 1'b0;
        seg_sel = 2'h0;
        bit_data = 1'b0;
        bit_valid = 1'b0;
        pwr_adc = 8'h00;
        pwr_adc_valid = 1'b0;
        wide_sel = 1'b0;
        cyc = 0;
        n_errors = 0;
        tests_run = 0;
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        foreach (ROWS[r]) begin
            run_pkt(ROWS[r]);
            $display("test packet %0d done", r);
        end
        apb(1'b1, ADDR_SETUP, 32'hFFFF_FFFF);
        rchk("setup mask", ADDR_SETUP, 32'h0000_00FF, 1'b0);
        apb(1'b1, ADDR_FILT, 32'hFFFF_FFFF);
        rchk("filter mask", ADDR_FILT, 32'h0000_00FF, 1'b0);
        apb(1'b1, ADDR_PLVL, 32'h0000_01C3);
        chk("level out", 32'h0000_00C3, {24'h0, tx_level});
        rchk("level read", ADDR_PLVL, 32'h0000_00C3, 1'b0);
        pwr_adc <= 8'h5A;
        pwr_adc_valid <= 1'b1;
        @(posedge pclk);
        pwr_adc_valid <= 1'b0;
        pwr_adc <= 8'h11;
        apb(1'b1, ADDR_PMEAS, 32'h0000_00FF);
        rchk("measure", ADDR_PMEAS, 32'h0000_005A, 1'b0);
        apb(1'b1, 8'h14, 32'h0000_0001);
        chk("unmapped write", 32'h1, {31'h0, er});
        rchk("unmapped read", 8'h14, 32'h0, 1'b1);
        chk("bus ready", 32'h1, {31'h0, pready});
        $display("test registers done");
        // reset lands mid-symbol while ST_LOAD is taking bits, so the state clear is hit with the coder busy
        tx_en <= 1'b1;
        bit_valid <= 1'b1;
        repeat (6) @(posedge pclk);
        presetn <= 1'b0;
        @(posedge pclk);
        chk("reset level", 32'h0, {24'h0, tx_level});
        chk("reset ready", 32'h0, {31'h0, bit_ready});
        chk("reset out", 32'h0, {7'h0, tx_out});
        presetn <= 1'b1;
        tx_en <= 1'b0;
        bit_valid <= 1'b0;
        @(posedge pclk);
        rchk("setup reset", ADDR_SETUP, {24'h0, SETUP_RST}, 1'b0);
        rchk("filter reset", ADDR_FILT, {24'h0, FILT_RST}, 1'b0);
        rchk("status reset", ADDR_STAT, 32'h0, 1'b0);
        run_pkt(ROWS[3]);
        $display("test reset done");
        wrap_up();
    end
endmodule : dsm_tx_modulator_test
`default_nettype wire
